// >>> dv/pfs_flow_tb.sv
// Self-checking bench for the flow and return stack block
`timescale 1ns/1ns
`default_nettype none
module pfs_flow_tb;
  import pfs_pkg::*;
  logic clk = 0, rst = 1, csr = 0, rw = 0;
  logic [9:0] ops = '0;
  logic [10:0] opnd = '0;
  logic [1:0] pg = '0;
  logic [12:0] tgt = '0, pa, ip;
  logic [7:0] ra = '0;
  logic [3:0] wd = '0, rd, idx;
  logic [15:0] pd = '0, tb;
  int fail_count = 0, checked = 0, cyc = 0, mip = 0, mi = 7, st[8];
  always #5 clk = ~clk;
  pfs_flow pfs_flow_inst (.clk(clk), .rst(rst), .clock_stop_rst(csr),
    .jump_op(ops[0]), .call_op(ops[1]), .jump_ind_op(ops[2]),
    .call_ind_op(ops[3]), .table_fetch_op(ops[4]), .return_op(ops[5]),
    .return_skip_op(ops[6]), .return_from_irq_op(ops[7]), .page_sel(pg),
    .operand(opnd), .indirect_target_reg(tgt), .irq_ext_accept(ops[8]),
    .irq_timer_accept(ops[9]), .reg_wr(rw), .reg_addr(ra), .reg_wdata(wd),
    .reg_rdata(rd), .prog_addr(pa), .prog_data(pd), .table_read_buffer(tb),
    .instr_pointer(ip), .return_slot_index(idx));
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Slot 7 has no storage and always reads zero
  task automatic push(input int v);
    mi = (mi + 7) % 8;
    if (mi != 7) st[mi] = v % 8192;
  endtask : push
  task automatic pop;
    mip = st[mi];
    mi = (mi + 1) % 8;
  endtask : pop
  // Codes 0-9 pulse one op, 10 register write, 11 clock stop, 12 reset
  task automatic op(input int k);
    int oi, ret;
    oi = mi;
    ret = (mip + 1) % 8192;
    if (k < 10) ops[k] <= 1'b1;
    rw <= (k == 10);
    csr <= (k == 11);
    rst <= (k == 12);
    pg <= 2'($urandom);
    opnd <= 11'($urandom_range(11'h5ff, 0));
    tgt <= 13'($urandom_range(13'h1dff, 0));
    ra <= ($urandom % 2) ? PFS_IDX_ADDR : 8'($urandom);
    wd <= 4'($urandom);
    pd <= 16'($urandom);
    @(posedge clk);
    ops <= '0;
    rw <= 1'b0;
    csr <= 1'b0;
    rst <= 1'b0;
    mip = ret;
    case (k)
      0: mip = pg * 2048 + opnd;
      1: begin push(ret); mip = opnd; end
      2: mip = tgt;
      3: begin push(ret); mip = tgt; end
      4: push(ret);
      5, 6, 7: pop();
      8: begin push(ret); mip = 5; end
      9: begin push(ret); mip = 3; end
      10: if (ra == PFS_IDX_ADDR) mi = wd % 8;
      11: mi = 7;
      12: begin mi = 7; mip = 0; end
    endcase
    @(negedge clk);
    chk(idx, 16'(mi));
    chk(rd, (k == 12) ? 16'h0 : 16'(oi));
    if (k != 4) chk(ip, 16'(mip));
    else chk(pa, 16'(tgt));
    if (k == 4) begin
      @(posedge clk);
      pop();
      @(negedge clk);
      chk(ip, 16'(mip));
      chk(tb, pd);
      chk(idx, 16'(mi));
    end
    @(posedge clk);
    mip = (mip + 1) % 8192;
  endtask : op
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    void'($urandom(32'h39fba7b1));
    repeat (10) @(posedge clk);
    op(5);
    // Return once from the empty slot 7, then fill slots 0 to 6 with eight calls, the first landing in slot 7
    repeat (8) op(1);
    for (int k = 0; k < 13; k++) op(k);
    $display("directed test done");
    for (int n = 0; n < 600; n++) op($urandom_range(12, 0));
    $display("random test done");
    test_done();
  end
endmodule : pfs_flow_tb
`default_nettype wire

// >>> rtl/pfs_flow.sv
// Instruction pointer and seven-slot return-address stack
// Functional notes
// - Return-slot index is a 4-bit counter; low three bits pick the slot.
// - Index values 000 to 111 address slots 0 to 7; index alone selects.
// - Eight logical 16-bit slots; only 0 to 6 hold storage.
// - Upper 3 bits of slots are zero (4 bits on 12-bit variant).
// - Calls, table fetches and accepted interrupts push a return address.
// - Index readable and writable at register 01H; bit 3 reads zero.
// - Power-on and chip-enable reset clear the instruction pointer.
// - Jump takes page bits from encoding; call forces page 00.
// - Interrupt vectors: external pin 0005H first, timer 0003H second.
// - Push decrements index first, then stores in the new slot.
// - Return loads pointer from current slot, then increments index.
// - Table fetch reads memory at target into buffer, then returns.
// - Slot 7 reads undefined; deep nesting returns to undefined address. Here slot 7 reads 0000H, so such a return goes to 0000H.
`timescale 1ns/1ns
`default_nettype none
module pfs_flow
  import pfs_pkg::*;
#(
  parameter int PTR_W = 13
) (
  // Clock and resets
  input wire logic clk,
  input wire logic rst,
  input wire logic clock_stop_rst,
  // Decoded operations
  input wire logic jump_op,
  input wire logic call_op,
  input wire logic jump_ind_op,
  input wire logic call_ind_op,
  input wire logic table_fetch_op,
  input wire logic return_op,
  input wire logic return_skip_op,
  input wire logic return_from_irq_op,
  input wire logic [1:0] page_sel,
  input wire logic [10:0] operand,
  input wire logic [12:0] indirect_target_reg,
  // Interrupt acceptance
  input wire logic irq_ext_accept,
  input wire logic irq_timer_accept,
  // Register manipulation port
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [3:0] reg_wdata,
  output logic [3:0] reg_rdata,
  // Program memory table read
  output logic [12:0] prog_addr,
  input wire logic [15:0] prog_data,
  output logic [15:0] table_read_buffer,
  // State
  output logic [12:0] instr_pointer,
  output logic [3:0] return_slot_index
);
  localparam int ZERO_W = 16 - PTR_W;

  logic [PTR_W-1:0] return_slot [PFS_SLOTS];
  pfs_state_e state;
  logic [12:0] ret_addr;
  logic push;
  logic ret_any;
  logic [3:0] next_idx;
  logic [15:0] cur_slot;
  logic irq_any;

  function automatic logic [15:0] slot_read(input logic [2:0] sel,
      input logic [PTR_W-1:0] val);
    if (sel == PFS_EMPTY_SLOT) begin
      slot_read = PFS_UNDEF_SLOT;
    end else begin
      slot_read = {{ZERO_W{1'b0}}, val};
    end
  endfunction : slot_read

  assign irq_any = irq_ext_accept | irq_timer_accept;
  assign push = call_op | call_ind_op | table_fetch_op | irq_any;
  assign ret_any = return_op | return_skip_op | return_from_irq_op;
  assign ret_addr = instr_pointer + 13'h0001;
  assign cur_slot = slot_read(return_slot_index[2:0],
      return_slot[return_slot_index[2:0] == PFS_EMPTY_SLOT ? 3'h0
                  : return_slot_index[2:0]]);

  // Index counter
  always_comb begin
    next_idx = return_slot_index;
    if (push && state == PFS_IDLE) begin
      next_idx = return_slot_index - 4'h1;
    end else if (ret_any || state == PFS_TBL_RESTORE) begin
      next_idx = return_slot_index + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || clock_stop_rst) begin
      return_slot_index <= PFS_IDX_RESET;
    end else if (reg_wr && reg_addr == PFS_IDX_ADDR) begin
      return_slot_index <= {1'b0, reg_wdata[2:0]};
    end else begin
      return_slot_index <= {1'b0, next_idx[2:0]};
    end
  end

  // Slot storage, written at the decremented index
  always_ff @(posedge clk) begin
    if (push && state == PFS_IDLE && next_idx[2:0] != PFS_EMPTY_SLOT) begin
      return_slot[next_idx[2:0]] <= ret_addr[PTR_W-1:0];
    end
  end

  // Table fetch sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= PFS_IDLE;
      table_read_buffer <= 16'h0000;
    end else begin
      case (state)
        PFS_IDLE: begin
          if (table_fetch_op && !irq_any) begin
            state <= PFS_TBL_RESTORE;
          end
        end
        PFS_TBL_RESTORE: begin
          table_read_buffer <= prog_data;
          state <= PFS_IDLE;
        end
        default: state <= PFS_IDLE;
      endcase
    end
  end

  // Instruction pointer
  always_ff @(posedge clk) begin
    if (rst) begin
      instr_pointer <= PFS_PTR_RESET;
    end else if (state == PFS_TBL_RESTORE) begin
      instr_pointer <= cur_slot[12:0];
    end else if (irq_ext_accept) begin
      instr_pointer <= PFS_VEC_EXT;
    end else if (irq_timer_accept) begin
      instr_pointer <= PFS_VEC_TIMER;
    end else if (jump_op) begin
      instr_pointer <= {page_sel, operand};
    end else if (call_op) begin
      instr_pointer <= {PFS_CALL_PAGE, operand};
    end else if (jump_ind_op || call_ind_op) begin
      instr_pointer <= indirect_target_reg;
    end else if (ret_any) begin
      instr_pointer <= cur_slot[12:0];
    end else if (!table_fetch_op) begin
      instr_pointer <= ret_addr;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prog_addr <= 13'h0000;
      reg_rdata <= 4'h0;
    end else begin
      prog_addr <= table_fetch_op ? indirect_target_reg : instr_pointer;
      reg_rdata <= {1'b0, return_slot_index[2:0]};
    end
  end

  chk_reset_index: assert property (@(posedge clk)
    rst |=> return_slot_index == PFS_IDX_RESET)
    else $error("index not 7 after reset");
  chk_reset_ptr: assert property (@(posedge clk)
    rst |=> instr_pointer == 13'h0000)
    else $error("pointer not zero after reset");
  chk_push_dec: assert property (@(posedge clk) disable iff (rst)
    (call_op && state == PFS_IDLE && !reg_wr && !clock_stop_rst) |=>
    return_slot_index[2:0] == $past(return_slot_index[2:0]) - 3'h1)
    else $error("push did not decrement index");
  chk_ret_inc: assert property (@(posedge clk) disable iff (rst)
    (return_op && !push && !reg_wr && !clock_stop_rst) |=>
    return_slot_index[2:0] == $past(return_slot_index[2:0]) + 3'h1)
    else $error("return did not increment index");
  chk_ext_vec: assert property (@(posedge clk) disable iff (rst)
    (irq_ext_accept && state == PFS_IDLE) |=> instr_pointer == PFS_VEC_EXT)
    else $error("external vector wrong");
  chk_call_page: assert property (@(posedge clk) disable iff (rst)
    (call_op && !irq_any && !jump_op && state == PFS_IDLE) |=>
    instr_pointer[12:11] == 2'b00)
    else $error("call page not zero");
  chk_bit3_zero: assert property (@(posedge clk) disable iff (rst)
    ##1 reg_rdata[3] == 1'b0)
    else $error("index bit 3 read as one");
  chk_tbl_restore: assert property (@(posedge clk) disable iff (rst)
    (table_fetch_op && !irq_any && state == PFS_IDLE) |=>
    state == PFS_TBL_RESTORE ##1 state == PFS_IDLE)
    else $error("table fetch sequence wrong");
  chk_ind_jump: assert property (@(posedge clk) disable iff (rst)
    (jump_ind_op && !irq_any && !jump_op && !call_op && state == PFS_IDLE)
    |=> instr_pointer == $past(indirect_target_reg))
    else $error("indirect jump target wrong");
  chk_timer_vec: assert property (@(posedge clk) disable iff (rst)
    (irq_timer_accept && !irq_ext_accept && state == PFS_IDLE) |=>
    instr_pointer == PFS_VEC_TIMER)
    else $error("timer vector wrong");
  chk_jump_page: assert property (@(posedge clk) disable iff (rst)
    (jump_op && !irq_any && state == PFS_IDLE) |=>
    instr_pointer == {$past(page_sel), $past(operand)})
    else $error("jump target wrong");
  chk_push_store: assert property (@(posedge clk) disable iff (rst)
    (push && state == PFS_IDLE && !reg_wr && !clock_stop_rst &&
    next_idx[2:0] != PFS_EMPTY_SLOT) |=>
    cur_slot[PTR_W-1:0] == $past(ret_addr[PTR_W-1:0]))
    else $error("return address not stored");
  chk_ret_ptr: assert property (@(posedge clk) disable iff (rst)
    (ret_any && !push && !jump_op && !jump_ind_op && state == PFS_IDLE) |=>
    instr_pointer == $past(cur_slot[12:0]))
    else $error("return pointer wrong");
  chk_idx_write: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && reg_addr == PFS_IDX_ADDR && !clock_stop_rst) |=>
    return_slot_index == {1'b0, $past(reg_wdata[2:0])})
    else $error("index write lost");
  chk_stop_index: assert property (@(posedge clk)
    clock_stop_rst |=> return_slot_index == PFS_IDX_RESET)
    else $error("index not 7 after clock stop");
  chk_tbl_buffer: assert property (@(posedge clk) disable iff (rst)
    state == PFS_TBL_RESTORE |=> table_read_buffer == $past(prog_data))
    else $error("table data not captured");
endmodule : pfs_flow
`default_nettype wire

// >>> rtl/pfs_pkg.sv
// Package for program flow and return stack constants
package pfs_pkg;
  localparam logic [3:0] PFS_IDX_RESET = 4'h7;
  localparam logic [7:0] PFS_IDX_ADDR = 8'h01;
  localparam logic [12:0] PFS_PTR_RESET = 13'h0000;
  localparam logic [12:0] PFS_VEC_EXT = 13'h0005;
  localparam logic [12:0] PFS_VEC_TIMER = 13'h0003;
  localparam logic [1:0] PFS_CALL_PAGE = 2'h0;
  localparam int PFS_SLOTS = 7;
  localparam logic [2:0] PFS_EMPTY_SLOT = 3'h7;
  localparam logic [15:0] PFS_UNDEF_SLOT = 16'h0000;
  typedef enum logic [1:0] {
    PFS_IDLE = 2'b00,
    PFS_TBL_RESTORE = 2'b01
  } pfs_state_e;
endpackage : pfs_pkg
